// >>> sbt_pkg.sv
// strobe timing package: register map, field layout, reset values and the
// carrier structs shared by the byte lane strobe timing block.
// assumes a 32-bit apb register bus with byte addresses on paddr.
package sbt_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_PHY_GCR        = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_STROBE_TIMING  = 12'h1d4;
   localparam logic [ADDR_W-1:0] ADDR_BYTE1_GCR      = 12'h200;
   localparam logic [ADDR_W-1:0] ADDR_LANE_STATUS    = 12'h204;

   // ****************************************
   // strobe timing field layout
   // ****************************************
   localparam int unsigned RANKS      = 4;
   localparam int unsigned MASK_LSB   = 26;
   localparam int unsigned MASK_W     = 4;
   localparam int unsigned MASK_HALF  = 2;
   localparam int unsigned CSTR_LSB   = 23;
   localparam int unsigned TSTR_LSB   = 20;
   localparam int unsigned STR_W      = 3;
   localparam int unsigned OFS_W      = 4;
   localparam int unsigned PHASE_LSB  = 12;
   localparam int unsigned PHASE_W    = 2;
   localparam int unsigned LAT_LSB    = 0;
   localparam int unsigned LAT_W      = 3;

   localparam logic [MASK_W-1:0]  MASK_RST    = 4'hf;
   localparam logic [STR_W-1:0]   STR_RST     = 3'h3;
   localparam logic [OFS_W-1:0]   STR_NOMINAL = 4'h3;
   localparam logic [PHASE_W-1:0] PHASE_RST   = 2'h1;
   localparam logic [LAT_W-1:0]   LAT_RST     = 3'h0;
   localparam logic [LAT_W-1:0]   LAT_MAX     = 3'h5;

   // ****************************************
   // other registers
   // ****************************************
   localparam int unsigned GCR_W       = 14;
   localparam logic [GCR_W-1:0] GCR_RST = 14'h0681;
   localparam int unsigned DRIFT_DIS_BIT = 0;
   localparam logic DRIFT_DIS_RST      = 1'b0;
   localparam int unsigned DONE_LSB    = 0;
   localparam int unsigned ERR_LSB     = 4;
   localparam int unsigned IERR_LSB    = 8;

   // gating clock codes
   typedef enum logic [PHASE_W-1:0]
   {
      SBT_PH_90  = 2'h0,
      SBT_PH_180 = 2'h1,
      SBT_PH_270 = 2'h2,
      SBT_PH_0   = 2'h3
   } sbt_gate_phase_t;

   // one-hot gating clock select: bit0 clk0, bit1 clk90, bit2 clk180, bit3 clk270
   localparam int unsigned GSEL_W = 4;

   // training engine writes one rank per pulse
   typedef struct packed {
      logic                valid;
      logic [1:0]          rank;
      logic [PHASE_W-1:0]  phase;
      logic [LAT_W-1:0]    latency;
   } sbt_train_upd_t;

   // drift compensation updates the gating phase only
   typedef struct packed {
      logic                valid;
      logic [1:0]          rank;
      logic [PHASE_W-1:0]  phase;
   } sbt_drift_upd_t;

   typedef struct packed {
      logic [RANKS-1:0] done;
      logic [RANKS-1:0] err;
      logic [RANKS-1:0] ierr;
   } sbt_train_status_t;

   // decoded delay settings towards the delay lines
   typedef struct packed {
      logic [MASK_HALF-1:0] mask_true_steps;
      logic [MASK_HALF-1:0] mask_comp_steps;
      logic signed [OFS_W-1:0] true_strobe_ofs;
      logic signed [OFS_W-1:0] comp_strobe_ofs;
   } sbt_lane_delay_t;

endpackage

// >>> sbt_strobe_timing.sv
// byte lane strobe timing and read gating control with its apb registers.
// assumes training, drift compensation and status inputs are synchronous
// to core_clk_i and that the read issue pulse comes from the controller.
`timescale 1ns/100ps

// Summary of operation
// - The four-bit mask delay field resets to all ones and its low half trims mask data taken by the true strobe.
// - The high half of the mask delay field trims mask data taken by the complement strobe on its own.
// - Each two-bit mask half adds zero to three delay steps, equal to its code.
// - True and complement strobe delays are separate three-bit fields that reset to three.
// - A strobe delay code gives an offset of the code minus three steps.
// - Each rank has a gating phase field choosing the clock that opens the read strobe gate.
// - Gating codes select clk90, clk180, clk270 and clk0 in order, resetting to clk180.
// - Gating fields are two bits per rank, rank 0 at bits 13:12 up to rank 3 at bits 19:18.
// - Training loads the gating fields and drift compensation updates them later.
// - Software writes replace gating values and drift updates stop when disabled by configuration.
// - Each rank has an extra read latency of zero to five cycles, resetting to zero.
// - Latency codes zero to five add that many cycles and codes six and seven are reserved.
// - Latency fields are three bits per rank, rank 0 at bits 2:0 up to rank 3 at bits 11:9.
// - Training writes the latency fields and a later software write overrides them.
// - Per-rank training done, error and intermittent error flags read back as status bits.
module sbt_strobe_timing
#(
   parameter int unsigned RANKS = sbt_pkg::RANKS
)
(
   // clock and reset
   input  wire logic                                core_clk_i,
   input  wire logic                                reset_i,
   // apb slave
   input  wire logic                                psel_i,
   input  wire logic                                penable_i,
   input  wire logic                                pwrite_i,
   input  wire logic [sbt_pkg::ADDR_W-1:0]          paddr_i,
   input  wire logic [31:0]                         pwdata_i,
   output logic      [31:0]                         prdata_o,
   output logic                                     pready_o,
   output logic                                     pslverr_o,
   // training, drift compensation and status
   input  wire sbt_pkg::sbt_train_upd_t             train_upd_i,
   input  wire sbt_pkg::sbt_drift_upd_t             drift_upd_i,
   input  wire sbt_pkg::sbt_train_status_t          train_status_i,
   // read issue from the controller
   input  wire logic                                rd_issue_i,
   input  wire logic [1:0]                          rd_rank_i,
   // outputs towards the delay lines and gating logic
   output sbt_pkg::sbt_lane_delay_t                 lane_delay_o,
   output logic [RANKS-1:0][sbt_pkg::GSEL_W-1:0]    gate_clk_sel_o,
   output logic [RANKS-1:0][sbt_pkg::LAT_W-1:0]     rank_extra_latency_o,
   output logic                                     rd_data_expect_o,
   output logic [sbt_pkg::GCR_W-1:0]                byte1_config_o,
   output logic                                     drift_update_disable_o
);

   // ****************************************
   // storage
   // ****************************************
   logic [sbt_pkg::MASK_W-1:0]              mask_delay_trim_reg;
   logic [sbt_pkg::STR_W-1:0]               true_strobe_delay_reg;
   logic [sbt_pkg::STR_W-1:0]               complement_strobe_delay_reg;
   logic [RANKS-1:0][sbt_pkg::PHASE_W-1:0]  rank_gate_phase_select_reg;
   logic [RANKS-1:0][sbt_pkg::LAT_W-1:0]    rank_gate_system_latency_reg;
   logic [sbt_pkg::GCR_W-1:0]               byte1_general_config_reg;
   logic                                    drift_disable_reg;
   logic [31:0]                             prdata_reg;
   logic                                    pslverr_reg;
   logic [sbt_pkg::LAT_MAX:0]               expect_reg;
   logic [sbt_pkg::LAT_MAX:0]               expect_next;

   logic                                    setup_phase;
   logic                                    wr_en;
   logic                                    wr_timing;
   logic                                    wr_byte1_gcr;
   logic                                    wr_phy_gcr;
   logic [31:0]                             rd_mux;
   logic                                    rd_hit;
   logic [sbt_pkg::LAT_W-1:0]               issue_lat;

   // ****************************************
   // apb decode
   // ****************************************
   // zero wait states: read data is caught in setup and shown in access
   assign setup_phase  = psel_i & ~penable_i;
   assign wr_en        = psel_i & penable_i & pwrite_i;
   assign wr_timing    = wr_en & (paddr_i == sbt_pkg::ADDR_STROBE_TIMING);
   assign wr_byte1_gcr = wr_en & (paddr_i == sbt_pkg::ADDR_BYTE1_GCR);
   assign wr_phy_gcr   = wr_en & (paddr_i == sbt_pkg::ADDR_PHY_GCR);

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr_i == sbt_pkg::ADDR_STROBE_TIMING)
      begin
         rd_mux[sbt_pkg::MASK_LSB +: sbt_pkg::MASK_W] = mask_delay_trim_reg;
         rd_mux[sbt_pkg::CSTR_LSB +: sbt_pkg::STR_W]  = complement_strobe_delay_reg;
         rd_mux[sbt_pkg::TSTR_LSB +: sbt_pkg::STR_W]  = true_strobe_delay_reg;
         for (int r = 0; r < RANKS; r++)
         begin
            rd_mux[sbt_pkg::PHASE_LSB + r*sbt_pkg::PHASE_W +: sbt_pkg::PHASE_W] =
               rank_gate_phase_select_reg[r];
            rd_mux[sbt_pkg::LAT_LSB + r*sbt_pkg::LAT_W +: sbt_pkg::LAT_W] =
               rank_gate_system_latency_reg[r];
         end
      end
      else if (paddr_i == sbt_pkg::ADDR_BYTE1_GCR)
      begin
         rd_mux[sbt_pkg::GCR_W-1:0] = byte1_general_config_reg;
      end
      else if (paddr_i == sbt_pkg::ADDR_LANE_STATUS)
      begin
         rd_mux[sbt_pkg::DONE_LSB +: sbt_pkg::RANKS] = train_status_i.done;
         rd_mux[sbt_pkg::ERR_LSB  +: sbt_pkg::RANKS] = train_status_i.err;
         rd_mux[sbt_pkg::IERR_LSB +: sbt_pkg::RANKS] = train_status_i.ierr;
      end
      else if (paddr_i == sbt_pkg::ADDR_PHY_GCR)
      begin
         rd_mux[sbt_pkg::DRIFT_DIS_BIT] = drift_disable_reg;
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
         pslverr_reg <= ~rd_hit;
      end
   end

   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_reg;
   assign pslverr_o = pslverr_reg & psel_i & penable_i;

   // ****************************************
   // strobe and mask delay fields
   // ****************************************
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mask_delay_trim_reg         <= sbt_pkg::MASK_RST;
         true_strobe_delay_reg       <= sbt_pkg::STR_RST;
         complement_strobe_delay_reg <= sbt_pkg::STR_RST;
      end
      else if (wr_timing)
      begin
         mask_delay_trim_reg         <= pwdata_i[sbt_pkg::MASK_LSB +: sbt_pkg::MASK_W];
         complement_strobe_delay_reg <= pwdata_i[sbt_pkg::CSTR_LSB +: sbt_pkg::STR_W];
         true_strobe_delay_reg       <= pwdata_i[sbt_pkg::TSTR_LSB +: sbt_pkg::STR_W];
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         lane_delay_o <= '0;
      end
      else
      begin
         lane_delay_o.mask_true_steps <= mask_delay_trim_reg[sbt_pkg::MASK_HALF-1:0];
         lane_delay_o.mask_comp_steps <=
            mask_delay_trim_reg[sbt_pkg::MASK_W-1:sbt_pkg::MASK_HALF];
         lane_delay_o.true_strobe_ofs <=
            {1'b0, true_strobe_delay_reg} - sbt_pkg::STR_NOMINAL;
         lane_delay_o.comp_strobe_ofs <=
            {1'b0, complement_strobe_delay_reg} - sbt_pkg::STR_NOMINAL;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         byte1_general_config_reg <= sbt_pkg::GCR_RST;
      end
      else if (wr_byte1_gcr)
      begin
         byte1_general_config_reg <= pwdata_i[sbt_pkg::GCR_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         drift_disable_reg <= sbt_pkg::DRIFT_DIS_RST;
      end
      else if (wr_phy_gcr)
      begin
         drift_disable_reg <= pwdata_i[sbt_pkg::DRIFT_DIS_BIT];
      end
   end

   assign byte1_config_o         = byte1_general_config_reg;
   assign drift_update_disable_o = drift_disable_reg;

   // ****************************************
   // per-rank gating phase and latency
   // ****************************************
   // software beats training, training beats drift in the same cycle
   for (genvar r = 0; r < RANKS; r++)
   begin : g_rank
      logic train_hit;
      logic drift_hit;

      assign train_hit = train_upd_i.valid & (train_upd_i.rank == 2'(r));
      assign drift_hit = drift_upd_i.valid & (drift_upd_i.rank == 2'(r)) & ~drift_disable_reg;

      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            rank_gate_phase_select_reg[r] <= sbt_pkg::PHASE_RST;
         end
         else if (wr_timing)
         begin
            rank_gate_phase_select_reg[r] <=
               pwdata_i[sbt_pkg::PHASE_LSB + r*sbt_pkg::PHASE_W +: sbt_pkg::PHASE_W];
         end
         else if (train_hit)
         begin
            rank_gate_phase_select_reg[r] <= train_upd_i.phase;
         end
         else if (drift_hit)
         begin
            rank_gate_phase_select_reg[r] <= drift_upd_i.phase;
         end
      end

      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            rank_gate_system_latency_reg[r] <= sbt_pkg::LAT_RST;
         end
         else if (wr_timing)
         begin
            rank_gate_system_latency_reg[r] <=
               pwdata_i[sbt_pkg::LAT_LSB + r*sbt_pkg::LAT_W +: sbt_pkg::LAT_W];
         end
         else if (train_hit)
         begin
            rank_gate_system_latency_reg[r] <= train_upd_i.latency;
         end
      end

      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            gate_clk_sel_o[r] <= 4'h4;
         end
         else
         begin
            case (sbt_pkg::sbt_gate_phase_t'(rank_gate_phase_select_reg[r]))
               sbt_pkg::SBT_PH_90:  gate_clk_sel_o[r] <= 4'h2;
               sbt_pkg::SBT_PH_180: gate_clk_sel_o[r] <= 4'h4;
               sbt_pkg::SBT_PH_270: gate_clk_sel_o[r] <= 4'h8;
               default:             gate_clk_sel_o[r] <= 4'h1;
            endcase
         end
      end
   end

   assign rank_extra_latency_o = rank_gate_system_latency_reg;

   // ****************************************
   // read data expect timing
   // ****************************************
   // reserved codes clamp to five so a bad setting cannot lose a read
   always_comb
   begin
      issue_lat = rank_gate_system_latency_reg[rd_rank_i];
      if (issue_lat > sbt_pkg::LAT_MAX)
      begin
         issue_lat = sbt_pkg::LAT_MAX;
      end
      expect_next = expect_reg >> 1;
      if (rd_issue_i)
      begin
         // expect valid data lat+1 cycles after the issue cycle
         expect_next[issue_lat] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         expect_reg <= '0;
      end
      else
      begin
         expect_reg <= expect_next;
      end
   end

   assign rd_data_expect_o = expect_reg[0];

endmodule

// >>> sbt_strobe_timing_checker.sv
// assertions on the strobe timing block ports, bound below.
// assumes the package map and the one-hot gate select code.
`timescale 1ns/100ps
module sbt_strobe_timing_checker
#(
   parameter int unsigned RANKS = 4
)
(
   // clock, reset and apb
   input wire logic                     core_clk_i,
   input wire logic                     reset_i,
   input wire logic                     psel_i,
   input wire logic                     penable_i,
   input wire logic                     pwrite_i,
   input wire logic [11:0]              paddr_i,
   input wire logic [31:0]              prdata_o,
   input wire logic                     pslverr_o,
   // updates, reads and lane settings
   input wire sbt_pkg::sbt_train_upd_t  train_upd_i,
   input wire sbt_pkg::sbt_drift_upd_t  drift_upd_i,
   input wire logic                     rd_issue_i,
   input wire logic [1:0]               rd_rank_i,
   input wire sbt_pkg::sbt_lane_delay_t lane_delay_o,
   input wire logic [RANKS-1:0][3:0]    gate_clk_sel_o,
   input wire logic [RANKS-1:0][2:0]    rank_extra_latency_o,
   input wire logic                     rd_data_expect_o,
   input wire logic                     drift_update_disable_o
);
   // ****************************************
   // helpers and properties
   // ****************************************
   logic       acc;
   logic       wr_st;
   logic [2:0] since;
   assign acc = psel_i && penable_i;
   assign wr_st = acc && pwrite_i && paddr_i == 12'h1d4;
   function automatic logic [3:0] oh(input logic [1:0] p);
      return (p == 2'h3) ? 4'h1 : 4'h2 << p;
   endfunction
   // cycles since the last read issue, saturating
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         since <= 3'h7;
      else if (rd_issue_i)
         since <= 3'h0;
      else if (since != 3'h7)
         since <= since + 3'h1;
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   sequence quiet_s;
      !train_upd_i.valid && !drift_upd_i.valid && !wr_st;
   endsequence
   sequence rd_st_s;
      acc && !pwrite_i && paddr_i == 12'h1d4;
   endsequence
   unmapped_error_a:
      assert property (acc && !(paddr_i inside {12'h010, 12'h1d4, 12'h200, 12'h204})
         |-> pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unmapped access");
   reserved_zero_a:
      assert property (rd_st_s |-> prdata_o[31:30] == 2'h0) else $error("reserved bits set");
   lane_delay_a:
      assert property (rd_st_s |-> lane_delay_o == {prdata_o[27:26], prdata_o[29:28],
         4'({1'b0, prdata_o[22:20]} - 4'h3), 4'({1'b0, prdata_o[25:23]} - 4'h3)})
         else $error("lane delay mismatch");
   gate_phase_a:
      assert property (rd_st_s |-> gate_clk_sel_o == {oh(prdata_o[19:18]),
         oh(prdata_o[17:16]), oh(prdata_o[15:14]), oh(prdata_o[13:12])})
         else $error("gate select mismatch");
   train_gate_a:
      assert property (train_upd_i.valid && !wr_st ##1 quiet_s |=>
         gate_clk_sel_o[$past(train_upd_i.rank, 2)] == oh($past(train_upd_i.phase, 2)))
         else $error("trained phase lost");
   train_latency_a:
      assert property (train_upd_i.valid && !wr_st |=>
         rank_extra_latency_o[$past(train_upd_i.rank)] == $past(train_upd_i.latency))
         else $error("trained latency lost");
   drift_on_a:
      assert property (drift_upd_i.valid && !drift_update_disable_o && !train_upd_i.valid
         && !wr_st ##1 quiet_s |=> gate_clk_sel_o[$past(drift_upd_i.rank, 2)]
         == oh($past(drift_upd_i.phase, 2))) else $error("drift update lost");
   drift_off_a:
      assert property (quiet_s ##1 drift_upd_i.valid && drift_update_disable_o
         && !train_upd_i.valid && !wr_st ##1 quiet_s |=> gate_clk_sel_o
         == $past(gate_clk_sel_o, 2)) else $error("disabled drift applied");
   expect_late_a:
      assert property (rd_issue_i && rank_extra_latency_o[rd_rank_i] >= 3'h5
         |-> ##6 rd_data_expect_o) else $error("late expect missing");
   no_stray_a:
      assert property (rd_data_expect_o |-> since <= 3'h5) else $error("stray expect");
endmodule
bind sbt_strobe_timing sbt_strobe_timing_checker #(.RANKS(RANKS)) checker_i
(
   .core_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pslverr_o,
   .train_upd_i, .drift_upd_i, .rd_issue_i, .rd_rank_i, .lane_delay_o, .gate_clk_sel_o,
   .rank_extra_latency_o, .rd_data_expect_o, .drift_update_disable_o
);

// >>> sbt_train_model.sv
// stand-in for the training engine and read scheduler beside the lane.
// assumes one caller per task at a time.
`timescale 1ns/100ps
module sbt_train_model
(
   // clock
   input  wire logic                  core_clk_i,
   // towards the lane block
   output sbt_pkg::sbt_train_upd_t    train_upd_o,
   output sbt_pkg::sbt_drift_upd_t    drift_upd_o,
   output sbt_pkg::sbt_train_status_t status_o,
   output logic                       rd_issue_o,
   output logic [1:0]                 rd_rank_o
);
   // ****************************************
   // one-cycle update pulses
   // ****************************************
   initial
      {train_upd_o, drift_upd_o, status_o, rd_issue_o, rd_rank_o} = '0;
   // released fields flip so a stale value never passes for a live one
   task automatic train(input logic [1:0] r, p, input logic [2:0] l);
      @(posedge core_clk_i);
      train_upd_o <= {1'b1, r, p, l};
      @(posedge core_clk_i);
      train_upd_o <= {1'b0, ~r, ~p, ~l};
   endtask
   task automatic drift(input logic [1:0] r, p);
      @(posedge core_clk_i);
      drift_upd_o <= {1'b1, r, p};
      @(posedge core_clk_i);
      drift_upd_o <= {1'b0, ~r, ~p};
   endtask
   // four back to back issues, rank i in rk[2i+1:2i]
   task automatic issue4(input logic [7:0] rk);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk_i);
         rd_issue_o <= 1'b1;
         rd_rank_o <= rk[2*i +: 2];
      end
      @(posedge core_clk_i);
      rd_issue_o <= 1'b0;
      rd_rank_o <= ~rk[7:6];
   endtask
   task automatic set_status(input logic [11:0] s);
      @(posedge core_clk_i);
      status_o <= s;
   endtask
endmodule

// >>> sbt_strobe_timing_tb.sv
// self-checking bench of the strobe timing block against a cycle model.
// assumes the training model drives all update and read inputs.
`timescale 1ns/100ps
module sbt_strobe_timing_tb;
   logic                       core_clk_i, reset_i, psel_i, penable_i, pwrite_i;
   logic [11:0]                paddr_i;
   logic [31:0]                pwdata_i, prdata_o;
   logic                       pready_o, pslverr_o, rd_issue_i, rd_data_expect_o;
   logic                       drift_update_disable_o, dis, eerr;
   logic [1:0]                 rd_rank_i;
   sbt_pkg::sbt_train_upd_t    train_upd_i;
   sbt_pkg::sbt_drift_upd_t    drift_upd_i;
   sbt_pkg::sbt_train_status_t train_status_i;
   sbt_pkg::sbt_lane_delay_t   lane_delay_o;
   logic [3:0][3:0]            gate_clk_sel_o;
   logic [3:0][2:0]            rank_extra_latency_o;
   logic [13:0]                byte1_config_o, gcr;
   logic [31:0]                st, prv, erd, seed, v;
   logic [7:0]                 sh;
   logic [11:0]                am [5];
   int                         error_cnt, check_count, live, l;
   sbt_strobe_timing sbt_strobe_timing_i
   (
      .core_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .train_upd_i, .drift_upd_i, .train_status_i, .rd_issue_i,
      .rd_rank_i, .lane_delay_o, .gate_clk_sel_o, .rank_extra_latency_o, .rd_data_expect_o,
      .byte1_config_o, .drift_update_disable_o
   );
   sbt_train_model sbt_train_model_i
   (
      .core_clk_i, .train_upd_o(train_upd_i), .drift_upd_o(drift_upd_i),
      .status_o(train_status_i), .rd_issue_o(rd_issue_i), .rd_rank_o(rd_rank_i)
   );
   // ****************************************
   // checking and cycle model
   // ****************************************
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [3:0] gs(input logic [1:0] p);
      return (p == 2'h3) ? 4'h1 : 4'h2 << p;
   endfunction
   function automatic logic [31:0] rdv(input logic [11:0] a);
      case (a)
         12'h1d4: rdv = st;
         12'h200: rdv = {18'h0, gcr};
         12'h204: rdv = {20'h0, train_status_i.ierr, train_status_i.err, train_status_i.done};
         12'h010: rdv = {31'h0, dis};
         default: rdv = 32'h0;
      endcase
   endfunction
   // inputs are sampled before this edge's updates land
   always @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st = 32'h3db55000;
         gcr = 14'h0681;
         dis = 1'b0;
         sh = 8'h0;
         live = 0;
      end
      else
      begin
         live++;
         if (live > 1)
         begin
            chk("expect", 32'(sh[0]), 32'(rd_data_expect_o));
            chk("latency", 32'(st[11:0]), 32'(rank_extra_latency_o));
            chk("gate", 32'({gs(prv[19:18]), gs(prv[17:16]), gs(prv[15:14]), gs(prv[13:12])}),
               32'(gate_clk_sel_o));
            chk("lane", 32'({prv[27:26], prv[29:28], 4'({1'b0, prv[22:20]} - 4'h3),
               4'({1'b0, prv[25:23]} - 4'h3)}), 32'(lane_delay_o));
            chk("config", 32'(gcr), 32'(byte1_config_o));
            chk("disable", 32'(dis), 32'(drift_update_disable_o));
         end
         if (psel_i && penable_i)
         begin
            if (!pwrite_i)
               chk("read", erd, prdata_o);
            chk("error", 32'(eerr), 32'(pslverr_o));
         end
         if (psel_i && !penable_i)
         begin
            erd = rdv(paddr_i);
            eerr = !(paddr_i inside {12'h010, 12'h1d4, 12'h200, 12'h204});
         end
         sh = sh >> 1;
         l = int'(st[3*rd_rank_i +: 3]);
         if (rd_issue_i)
            sh[(l > 5) ? 5 : l] = 1'b1;
         prv = st;
         if (drift_upd_i.valid && !dis)
            st[12 + 2*drift_upd_i.rank +: 2] = drift_upd_i.phase;
         if (train_upd_i.valid)
         begin
            st[12 + 2*train_upd_i.rank +: 2] = train_upd_i.phase;
            st[3*train_upd_i.rank +: 3] = train_upd_i.latency;
         end
         if (psel_i && penable_i && pwrite_i)
            case (paddr_i)
               12'h1d4: st = pwdata_i & 32'h3fffffff;
               12'h200: gcr = pwdata_i[13:0];
               12'h010: dis = pwdata_i[0];
               default: ;
            endcase
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 50);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1)
      begin
         chk("pready", 32'h1, 32'(pready_o));
         final_report();
      end
   endtask
   initial
   begin
      seed = 32'd51380;
      am = '{12'h1d4, 12'h200, 12'h204, 12'h010, 12'h300};
      {reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
      repeat (3) @(posedge core_clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 5; i++)
         apb(1'b0, am[i], 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         v = rnd();
         v[29:20] = {4'(i*2 + i/4), 3'(i), 3'(7 - i)};
         v[13:12] = 2'(i);
         apb(1'b1, 12'h1d4, v);
         apb(1'b0, 12'h1d4, 32'h0);
      end
      for (int i = 0; i < 4; i++)
         sbt_train_model_i.train(2'(i), 2'(3 - i), 3'(i + 2));
      sbt_train_model_i.issue4(8'he4);
      sbt_train_model_i.train(2'h0, 2'h0, 3'h0);
      sbt_train_model_i.train(2'h1, 2'h1, 3'h7);
      sbt_train_model_i.issue4(8'h14);
      repeat (8) @(posedge core_clk_i);
      apb(1'b0, 12'h1d4, 32'h0);
      sbt_train_model_i.drift(2'h2, 2'h3);
      repeat (2) @(posedge core_clk_i);
      apb(1'b1, 12'h010, 32'h1);
      sbt_train_model_i.drift(2'h2, 2'h0);
      repeat (2) @(posedge core_clk_i);
      fork
         apb(1'b1, 12'h1d4, 32'h0aaaa123);
         begin
            @(posedge core_clk_i);
            sbt_train_model_i.train(2'h3, 2'h2, 3'h4);
         end
      join
      sbt_train_model_i.set_status(12'(rnd()));
      apb(1'b1, 12'h204, 32'hffffffff);
      apb(1'b1, 12'h200, rnd());
      apb(1'b1, 12'h300, rnd());
      for (int i = 0; i < 5; i++)
         apb(1'b0, am[i], 32'h0);
      final_report();
   end
endmodule
